// ==== verilog/sbt_tap.sv ====
// boundary scan test access port of the synchronous memory
// assumes: tck_in from the test controller, at most 20 MHz;
// balls_in are the memory's input and bidirectional ball levels
`timescale 1ns/10ps
`default_nettype none
// Operation
// - five rising edges with mode select high reset port; memory untouched
// - power-up reset puts port in reset, data out undriven
// - one data register in serial path, chosen by current instruction
// - data in sampled on rising edge, data out changes on falling
// - three-bit instruction register loads IDCODE at reset and power-up
// - capture-IR loads binary 01 into two low instruction bits
// - one-bit bypass register, cleared to zero when bypass executes
// - capture-DR loads ball values; shift-DR shifts them serially
// - boundary register msb faces data in, lsb faces data out
// - IDCODE captures hardwired 32-bit code, shifted out in shift-DR
// - instructions shift in shift-IR, take effect at update-IR
// - no way to drive addresses, controls or output buffer values
// - all-zero instruction acts as sample and forces outputs high-z
// - with IDCODE active, shift-DR presents the code at data out
// - sample-z selects boundary register and holds outputs high-z
// - sample snapshot of balls at capture-DR, memory unaffected
// - update-DR under sample changes nothing, like a pause
// - bypass active in shift-DR: only bypass bit in path
// - codes: 000 extest, 001 idcode, 010 sample-z, 100 sample, 111 bypass
// - id bit 0 reads one; bits 31 to 29 read zero
// - boundary register is 71, 52 or 110 bits by organisation
// - mode select sampled on rising edge, pulled high internally
module sbt_tap (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output logic tms_pullup_en_out,
    output logic tdi_pullup_en_out,
    input wire logic [sbt_pkg::BSR_LEN-1:0] balls_in,
    output logic mem_hiz_out,
    output logic [2:0] instr_out
);
    sbt_pkg::sbt_state_t state_reg;
    sbt_pkg::sbt_state_t state_next;
    logic [2:0] tms_high_reg;
    logic tap_rst;
    logic por_tck;
    logic [sbt_pkg::IR_LEN-1:0] ir_shift_reg;
    logic [sbt_pkg::IR_LEN-1:0] ir_reg;
    logic bypass_reg;
    logic [sbt_pkg::ID_LEN-1:0] id_reg;
    logic [sbt_pkg::BSR_LEN-1:0] bsr_reg;
    logic [sbt_pkg::BSR_LEN-1:0] balls_tck;
    logic hiz_tck_reg;
    logic hiz_core;
    logic hiz_reg;
    logic tdo_reg;
    logic tdo_oe_reg;
    logic [2:0] instr_reg;
    logic serial_bit;

    // which data register an instruction places in the path
    function automatic sbt_pkg::sbt_dr_sel_t dr_of(
        input logic [2:0] code
    );
        sbt_pkg::sbt_dr_sel_t sel;
        case (code)
            sbt_pkg::INS_IDCODE: sel = sbt_pkg::DR_IDCODE;
            sbt_pkg::INS_EXTEST,
            sbt_pkg::INS_SAMPLE_Z,
            sbt_pkg::INS_SAMPLE: sel = sbt_pkg::DR_BOUNDARY;
            // reserved codes fall back to bypass, keeping a 1-bit path
            default: sel = sbt_pkg::DR_BYPASS;
        endcase
        return sel;
    endfunction

    // instructions that tri-state the memory outputs
    function automatic logic hiz_of(input logic [2:0] code);
        return (code == sbt_pkg::INS_EXTEST) ||
            (code == sbt_pkg::INS_SAMPLE_Z);
    endfunction

    // the balls carry no pull devices here; the pad ring adds them
    assign tms_pullup_en_out = 1'b1;
    assign tdi_pullup_en_out = 1'b1;

    // power-up reset reaches the test clock domain through two flops
    sbt_sync #(
        .WIDTH(1)
    ) u_por_sync (
        .dst_clock_in(tck_in),
        .d_in(rst_in),
        .q_out(por_tck)
    );

    // balls are asynchronous to the test clock; values in flight
    // while captured stay unreliable
    sbt_sync #(
        .WIDTH(sbt_pkg::BSR_LEN)
    ) u_ball_sync (
        .dst_clock_in(tck_in),
        .d_in(balls_in),
        .q_out(balls_tck)
    );

    assign tap_rst = por_tck;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sbt_pkg::ST_RESET: state_next = tms_in ? sbt_pkg::ST_RESET :
                sbt_pkg::ST_IDLE;
            sbt_pkg::ST_IDLE: state_next = tms_in ? sbt_pkg::ST_SEL_DR :
                sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_DR: state_next = tms_in ? sbt_pkg::ST_SEL_IR :
                sbt_pkg::ST_CAP_DR;
            sbt_pkg::ST_CAP_DR: state_next = tms_in ? sbt_pkg::ST_EXIT1_DR :
                sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_SHIFT_DR: state_next = tms_in ?
                sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_EXIT1_DR: state_next = tms_in ? sbt_pkg::ST_UPD_DR :
                sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_PAUSE_DR: state_next = tms_in ?
                sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_EXIT2_DR: state_next = tms_in ? sbt_pkg::ST_UPD_DR :
                sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_UPD_DR: state_next = tms_in ? sbt_pkg::ST_SEL_DR :
                sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_IR: state_next = tms_in ? sbt_pkg::ST_RESET :
                sbt_pkg::ST_CAP_IR;
            sbt_pkg::ST_CAP_IR: state_next = tms_in ? sbt_pkg::ST_EXIT1_IR :
                sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_SHIFT_IR: state_next = tms_in ?
                sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_EXIT1_IR: state_next = tms_in ? sbt_pkg::ST_UPD_IR :
                sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_PAUSE_IR: state_next = tms_in ?
                sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_EXIT2_IR: state_next = tms_in ? sbt_pkg::ST_UPD_IR :
                sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_UPD_IR: state_next = tms_in ? sbt_pkg::ST_SEL_DR :
                sbt_pkg::ST_IDLE;
            default: state_next = sbt_pkg::ST_RESET;
        endcase
    end

    // count of consecutive high mode-select edges, saturating
    always_ff @(posedge tck_in) begin
        if (tap_rst || !tms_in) begin
            tms_high_reg <= 3'h0;
        end else if (tms_high_reg != 3'(sbt_pkg::TMS_RESET_EDGES)) begin
            tms_high_reg <= tms_high_reg + 3'h1;
        end
    end

    // the state graph already lands in reset after five highs; the
    // counter forces it as well, guarding against a corrupt state
    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            state_reg <= sbt_pkg::ST_RESET;
        end else if (tms_in &&
                tms_high_reg == 3'(sbt_pkg::TMS_RESET_EDGES - 1)) begin
            state_reg <= sbt_pkg::ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // instruction shift path
    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            ir_shift_reg <= sbt_pkg::INS_IDCODE;
        end else if (state_reg == sbt_pkg::ST_CAP_IR) begin
            ir_shift_reg <= {sbt_pkg::IR_CAPTURE_MSB,
                sbt_pkg::IR_CAPTURE_LOW};
        end else if (state_reg == sbt_pkg::ST_SHIFT_IR) begin
            ir_shift_reg <= {tdi_in, ir_shift_reg[2:1]};
        end
    end

    // current instruction, changed at update-IR and set back to IDCODE in the reset state
    always_ff @(posedge tck_in) begin
        if (tap_rst || state_reg == sbt_pkg::ST_RESET) begin
            ir_reg <= sbt_pkg::INS_IDCODE;
        end else if (state_reg == sbt_pkg::ST_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            bypass_reg <= 1'b0;
        end else if (dr_of(ir_reg) == sbt_pkg::DR_BYPASS) begin
            if (state_reg == sbt_pkg::ST_CAP_DR) begin
                bypass_reg <= 1'b0;
            end else if (state_reg == sbt_pkg::ST_SHIFT_DR) begin
                bypass_reg <= tdi_in;
            end
        end
    end

    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            id_reg <= sbt_pkg::ID_CODE;
        end else if (dr_of(ir_reg) == sbt_pkg::DR_IDCODE) begin
            if (state_reg == sbt_pkg::ST_CAP_DR) begin
                id_reg <= sbt_pkg::ID_CODE;
            end else if (state_reg == sbt_pkg::ST_SHIFT_DR) begin
                id_reg <= {tdi_in, id_reg[31:1]};
            end
        end
    end

    // capture only: nothing here reaches the memory, and update-DR
    // leaves the register as a pause would
    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            bsr_reg <= '0;
        end else if (dr_of(ir_reg) == sbt_pkg::DR_BOUNDARY) begin
            if (state_reg == sbt_pkg::ST_CAP_DR) begin
                bsr_reg <= balls_tck;
            end else if (state_reg == sbt_pkg::ST_SHIFT_DR) begin
                bsr_reg <= {tdi_in,
                    bsr_reg[sbt_pkg::BSR_LEN-1:1]};
            end
        end
    end

    // one register alone drives the serial output
    always_comb begin
        serial_bit = bypass_reg;
        if (state_reg == sbt_pkg::ST_SHIFT_IR) begin
            serial_bit = ir_shift_reg[0];
        end else begin
            case (dr_of(ir_reg))
                sbt_pkg::DR_IDCODE: serial_bit = id_reg[0];
                sbt_pkg::DR_BOUNDARY: serial_bit = bsr_reg[0];
                sbt_pkg::DR_BYPASS: serial_bit = bypass_reg;
                default: serial_bit = bypass_reg;
            endcase
        end
    end

    // falling edge keeps half a period of hold for the controller
    always_ff @(negedge tck_in) begin
        if (tap_rst) begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else begin
            tdo_reg <= serial_bit;
            tdo_oe_reg <= (state_reg == sbt_pkg::ST_SHIFT_DR) ||
                (state_reg == sbt_pkg::ST_SHIFT_IR);
        end
    end

    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            hiz_tck_reg <= 1'b0;
        end else begin
            hiz_tck_reg <= hiz_of(ir_reg);
        end
    end

    // tri-state request crosses to the memory clock as a level
    sbt_sync #(
        .WIDTH(1)
    ) u_hiz_sync (
        .dst_clock_in(clock_in),
        .d_in(hiz_tck_reg),
        .q_out(hiz_core)
    );

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hiz_reg <= 1'b0;
        end else begin
            hiz_reg <= hiz_core;
        end
    end

    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            instr_reg <= sbt_pkg::INS_IDCODE;
        end else begin
            instr_reg <= ir_reg;
        end
    end

    assign tdo_out = tdo_reg;
    assign tdo_oe_out = tdo_oe_reg;
    assign mem_hiz_out = hiz_reg;
    assign instr_out = instr_reg;
endmodule
`default_nettype wire

// ==== verilog/sbt_pkg.sv ====
// constants and types for the sram boundary scan test port
// assumes: included before every design file of the block
package sbt_pkg;
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    // ball count of the 36-bit part; 52 for x18, 110 for x72
    localparam int BSR_LEN = 71;
    localparam int TMS_RESET_EDGES = 5;

    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
    localparam logic IR_CAPTURE_MSB = 1'h0;

    localparam logic [2:0] ID_REVISION = 3'h0;
    localparam logic [4:0] ID_DEPTH = 5'h0B;
    localparam logic [5:0] ID_ARCH = 6'h09;
    localparam logic [5:0] ID_WIDTH = 6'h24;
    // arbitrary vendor field, names no maker
    localparam logic [10:0] ID_VENDOR = 11'h2A5;
    localparam logic ID_PRESENT = 1'h1;
    localparam logic [31:0] ID_CODE = {ID_REVISION, ID_DEPTH, ID_ARCH,
        ID_WIDTH, ID_VENDOR, ID_PRESENT};

    // capture hold and setup around a rising test clock edge
    localparam int CAPTURE_HOLD_TIME_NS = 5;
    localparam int CAPTURE_SETUP_TIME_NS = 5;
    localparam int TCK_MAX_MHZ = 20;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sbt_state_t;

    typedef enum logic [2:0] {
        DR_BYPASS = 3'h1,
        DR_IDCODE = 3'h2,
        DR_BOUNDARY = 3'h4
    } sbt_dr_sel_t;
endpackage

// ==== verilog/sbt_sync.sv ====
// two flip-flop synchroniser for levels entering a clock domain
// assumes: each bit is a level that holds for several target cycles
`timescale 1ns/10ps
`default_nettype none
module sbt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic dst_clock_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage feeds only the second
    always_ff @(posedge dst_clock_in) begin
        meta_reg <= d_in;
        sync_reg <= meta_reg;
    end

    assign q_out = sync_reg;
endmodule
`default_nettype wire

// ==== verif/sbt_tap_asserts.sv ====
// assertions on the test port pins, bound into sbt_tap
// assumes: tck stops only in idle; rst_in spans three tck rises
`timescale 1ns/10ps
`default_nettype none
module sbt_tap_asserts (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic mem_hiz_out,
    input wire logic [2:0] instr_out
);
    property p_tap_reset;
        @(posedge tck_in) disable iff (rst_in)
        tms_in [*5] |-> ##[1:4] instr_out == sbt_pkg::INS_IDCODE;
    endproperty
    a_tap_reset: assert property (p_tap_reset)
        else $error("tap reset left instruction wrong");
    property p_release_quiet;
        @(posedge clock_in) disable iff (rst_in)
        $fell(rst_in) |-> !tdo_oe_out && !mem_hiz_out;
    endproperty
    a_release_quiet: assert property (p_release_quiet)
        else $error("port not quiet after reset");
    // tck high on two samples cannot hide a fall between them
    property p_tdo_fall_only;
        @(posedge clock_in) disable iff (rst_in)
        tck_in && $past(tck_in) |-> $stable(tdo_out) && $stable(tdo_oe_out);
    endproperty
    a_tdo_fall_only: assert property (p_tdo_fall_only)
        else $error("serial out moved while tck high");
    property p_oe_enter;
        @(posedge tck_in) disable iff (rst_in)
        $rose(tdo_oe_out) |-> !$past(tms_in);
    endproperty
    a_oe_enter: assert property (p_oe_enter)
        else $error("output enabled without a shift entry");
    property p_oe_leave;
        @(posedge tck_in) disable iff (rst_in)
        $fell(tdo_oe_out) |-> $past(tms_in);
    endproperty
    a_oe_leave: assert property (p_oe_leave)
        else $error("output released without a shift exit");
    property p_hiz_on;
        @(posedge clock_in) disable iff (rst_in)
        $rose(mem_hiz_out) |-> ##[0:8] (instr_out == sbt_pkg::INS_EXTEST
            || instr_out == sbt_pkg::INS_SAMPLE_Z);
    endproperty
    a_hiz_on: assert property (p_hiz_on)
        else $error("high-z raised by wrong instruction");
    property p_hiz_off;
        @(posedge clock_in) disable iff (rst_in)
        $fell(mem_hiz_out) |-> ##[0:8] !(instr_out == sbt_pkg::INS_EXTEST
            || instr_out == sbt_pkg::INS_SAMPLE_Z);
    endproperty
    a_hiz_off: assert property (p_hiz_off)
        else $error("high-z dropped under a high-z instruction");
    // update-IR is entered on a tms high rise
    property p_instr_update;
        @(posedge tck_in) disable iff (rst_in)
        $changed(instr_out) |-> $past(tms_in, 2) || $past(tms_in, 3);
    endproperty
    a_instr_update: assert property (p_instr_update)
        else $error("instruction changed outside update");
endmodule
bind sbt_tap sbt_tap_asserts sbt_tap_asserts_inst (.clock_in(clock_in),
    .rst_in(rst_in), .tck_in(tck_in), .tms_in(tms_in),
    .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .mem_hiz_out(mem_hiz_out), .instr_out(instr_out));
`default_nettype wire

// ==== verif/sbt_jtag_ctl.sv ====
// model of the board test controller on the four-wire port
// assumes: bench calls its tasks in turn; tck still between them
`timescale 1ns/10ps
`default_nettype none
module sbt_jtag_ctl (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_in
);
    logic last_bit;
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
        last_bit = 1'b0;
    end
    // 15 ns stresses the logic; boards keep tck at 20 MHz or less
    task automatic step(input logic mode, input logic din,
        output logic dout);
        tms_out = mode;
        tdi_out = din;
        #7.5 tck_out = 1'b1;
        // undriven tdo floats: read the inverse so it never looks valid
        dout = tdo_oe_in ? tdo_in : ~last_bit;
        last_bit = dout;
        #7.5 tck_out = 1'b0;
    endtask
    // idle, one scan, update, idle twice so instr_out catches up
    task automatic scan(input logic ir, input int n,
        input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule
`default_nettype wire

// ==== verif/sbt_tap_test.sv ====
// self-checking bench for the test port with a controller model
// assumes: package, design, checker and controller model compiled first
`timescale 1ns/10ps
`default_nettype none
module sbt_tap_test;
    logic clk, rst, tck, tms, tdi, tdo, tdo_oe, tms_pu, tdi_pu, hiz, q;
    logic [2:0] instr;
    logic [sbt_pkg::BSR_LEN-1:0] balls;
    logic [127:0] got;
    int failures, compares;
    sbt_tap sbt_tap_inst (.clock_in(clk), .rst_in(rst), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .tms_pullup_en_out(tms_pu), .tdi_pullup_en_out(tdi_pu),
        .balls_in(balls), .mem_hiz_out(hiz), .instr_out(instr));
    sbt_jtag_ctl sbt_jtag_ctl_inst (.tck_out(tck), .tms_out(tms),
        .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [127:0] seen,
        input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic load_ir(input logic [2:0] code);
        sbt_jtag_ctl_inst.scan(1'b1, 3, 128'(code), got);
        check("capture_ir", got, 128'h1);
        check("instr", instr, code);
    endtask
    task automatic t_reset_state();
        check("instr", instr, sbt_pkg::INS_IDCODE);
        check("tdo_oe", tdo_oe, 1'b0);
        check("pullups", {tms_pu, tdi_pu}, 2'h3);
        sbt_jtag_ctl_inst.scan(1'b0, 32, '0, got);
        check("idcode", got, 128'(sbt_pkg::ID_CODE));
        check("id_ends", {got[31:29], got[0]}, 4'h1);
    endtask
    // the five defined codes; reserved ones never go on the wire
    task automatic t_codes();
        logic [2:0] code;
        logic bsr;
        logic [127:0] pat, exp;
        int n;
        for (int c = 0; c < 8; c++) begin
            if (c == 3 || c == 5 || c == 6)
                continue;
            code = 3'(c);
            bsr = code == 3'h0 || code == 3'h2 || code == 3'h4;
            pat = {4{32'hC3A50F96}} >> c;
            @(posedge clk);
            balls <= pat[70:0]; // held through capture
            #0.7;
            load_ir(code);
            n = code == 3'h1 ? 32 : bsr ? 72 : 8;
            exp = code == 3'h1 ? 128'(sbt_pkg::ID_CODE) :
                bsr ? {pat[0], pat[70:0]} : {pat[6:0], 1'b0};
            sbt_jtag_ctl_inst.scan(1'b0, n, pat, got);
            check("dr", got, exp);
            if (bsr) begin
                sbt_jtag_ctl_inst.scan(1'b0, 71, ~pat, got);
                check("recapture", got, 128'(pat[70:0]));
            end
            check("hiz", hiz, code == 3'h0 || code == 3'h2);
        end
    endtask
    task automatic t_tap_reset();
        load_ir(sbt_pkg::INS_EXTEST);
        repeat (5) sbt_jtag_ctl_inst.step(1'b1, 1'b1, q);
        // first idle rise lets the reset property see the new code
        repeat (3) sbt_jtag_ctl_inst.step(1'b0, 1'b1, q);
        repeat (4) @(posedge clk);
        check("reset_instr", instr, sbt_pkg::INS_IDCODE);
        check("reset_hiz", hiz, 1'b0);
    endtask
    initial begin
        rst = 1'b1;
        balls = '0;
        failures = 0;
        compares = 0;
        // tck offset keeps its edges off the memory clock grid
        fork
            repeat (16) @(posedge clk);
            begin
                #0.7;
                repeat (4) sbt_jtag_ctl_inst.step(1'b1, 1'b1, q);
            end
        join
        rst <= 1'b0;
        #0.7;
        repeat (3) sbt_jtag_ctl_inst.step(1'b1, 1'b1, q);
        sbt_jtag_ctl_inst.step(1'b0, 1'b1, q);
        t_reset_state();
        t_codes();
        t_tap_reset();
        finish_test();
    end
    // run needs about 10 us; six times that means a hang
    initial begin
        #60000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
